// ### rtl/rst_susp_pkg.sv
// shared constants for the reset and suspend controller
// assumes one clock domain (host bus clock)
package rst_susp_pkg;
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] SUPPLY_CTL_RST = 2'h0;
   localparam logic [1:0] PROG_CTL_RST = 2'h0;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h00;
endpackage : rst_susp_pkg

// ### rtl/sync2.sv
// two flip-flop level synchroniser
// assumes d comes from outside the core_clk domain
`timescale 1ns/1ps
module sync2
(
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic d,
   output logic q
);
   logic s1;
   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule : sync2

// ### rtl/reset_suspend_control.sv
// reset and suspend handling, card power switch control outputs
// assumes all pin inputs asynchronous to core_clk; ctl inputs from core logic
//
// Notes on behaviour
// - global reset without suspend tri-states outputs and clears registers to defaults.
// - global reset with suspend tri-states outputs but preserves register contents.
// - all bus inputs sampled on rising edge of the bus clock.
// - bus reset without suspend tri-states outputs, clears registers, blocks function.
// - after release of a bus reset without suspend, registers hold their reset values.
// - bus reset with suspend preserves registers while outputs are tri-stated.
// - two supply switch controls and two programming supply switch controls driven.
`timescale 1ns/1ps
module reset_suspend_control
   import rst_susp_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic global_reset_in_n,
   input wire logic host_bus_reset_in_n,
   input wire logic suspend_in,
   input wire logic [1:0] supply_req,
   input wire logic [1:0] prog_req,
   input wire logic [7:0] ctl_wdata,
   input wire logic ctl_we,
   output logic card_supply_switch_ctl0,
   output logic card_supply_switch_ctl1,
   output logic card_prog_switch_ctl0,
   output logic card_prog_switch_ctl1,
   output logic supply_oe,
   output logic prog_oe,
   output logic [7:0] ctl_reg,
   output logic func_en
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NUM_PINS = 3;
   logic global_reset_in_n_s;
   logic host_bus_reset_in_n_s;
   logic susp_s;
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_sync;

   // bit 0 global reset, bit 1 bus reset, bit 2 suspend
   assign pin_raw = {suspend_in, host_bus_reset_in_n, global_reset_in_n};

   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin_sync
      sync2 u_sync
      (
         .core_clk(core_clk),
         .clk_en(clk_en),
         .d(pin_raw[i]),
         .q(pin_sync[i])
      );
   end

   assign global_reset_in_n_s = pin_sync[0];
   assign host_bus_reset_in_n_s = pin_sync[1];
   assign susp_s = pin_sync[2];

   // ----------------------------------------
   // reset qualification
   // ----------------------------------------
   logic any_rst;
   logic clear_regs;
   assign any_rst = !global_reset_in_n_s || !host_bus_reset_in_n_s;
   // suspend shields register contents from either reset
   assign clear_regs = any_rst && !susp_s;

   // ----------------------------------------
   // internal registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         ctl_reg <= CTL_RST;
      else if (clk_en)
      begin
         if (clear_regs)
            ctl_reg <= CTL_RST;
         else if (!any_rst && ctl_we)
            ctl_reg <= ctl_wdata;
      end
   end

   // ----------------------------------------
   // switch controls and enables
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         card_supply_switch_ctl0 <= SUPPLY_CTL_RST[0];
         card_supply_switch_ctl1 <= SUPPLY_CTL_RST[1];
         card_prog_switch_ctl0 <= PROG_CTL_RST[0];
         card_prog_switch_ctl1 <= PROG_CTL_RST[1];
      end
      else if (clk_en)
      begin
         if (clear_regs)
         begin
            card_supply_switch_ctl0 <= SUPPLY_CTL_RST[0];
            card_supply_switch_ctl1 <= SUPPLY_CTL_RST[1];
            card_prog_switch_ctl0 <= PROG_CTL_RST[0];
            card_prog_switch_ctl1 <= PROG_CTL_RST[1];
         end
         else if (!any_rst)
         begin
            card_supply_switch_ctl0 <= supply_req[0];
            card_supply_switch_ctl1 <= supply_req[1];
            card_prog_switch_ctl0 <= prog_req[0];
            card_prog_switch_ctl1 <= prog_req[1];
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         supply_oe <= 1'b0;
         prog_oe <= 1'b0;
         func_en <= 1'b0;
      end
      else if (clk_en)
      begin
         supply_oe <= !any_rst;
         prog_oe <= !any_rst;
         func_en <= !any_rst;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_clear;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && clear_regs) |=> (ctl_reg == CTL_RST);
   endproperty
   a_clear: assert property (p_clear) else $error("registers not cleared");

   property p_oe_off;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && any_rst) |=> (!supply_oe && !prog_oe);
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs driven in reset");

   property p_keep;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && any_rst && susp_s) |=> $stable(ctl_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("registers lost in suspend");

   property p_keep_sw;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && any_rst && susp_s) |=> $stable(card_supply_switch_ctl0)
         && $stable(card_prog_switch_ctl1);
   endproperty
   a_keep_sw: assert property (p_keep_sw) else $error("switch state lost");

   property p_nofunc;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !host_bus_reset_in_n_s) |=> !func_en;
   endproperty
   a_nofunc: assert property (p_nofunc) else $error("function during reset");

   property p_release;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !any_rst && $past(clear_regs)) |-> (ctl_reg == CTL_RST);
   endproperty
   a_release: assert property (p_release) else $error("not default after release");

   property p_drive;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !any_rst) |=> (card_supply_switch_ctl1 == $past(supply_req[1])
         && card_prog_switch_ctl0 == $past(prog_req[0]));
   endproperty
   a_drive: assert property (p_drive) else $error("switch control wrong");

   property p_one_edge;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && any_rst) |=> !func_en;
   endproperty
   a_one_edge: assert property (p_one_edge) else $error("early release");

   property p_keep_prog;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && any_rst && susp_s) |=> $stable(card_supply_switch_ctl1)
         && $stable(card_prog_switch_ctl0);
   endproperty
   a_keep_prog: assert property (p_keep_prog) else $error("switch state lost");

   property p_clear_sw;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && clear_regs) |=>
         ({card_prog_switch_ctl1, card_prog_switch_ctl0} == PROG_CTL_RST
         && {card_supply_switch_ctl1, card_supply_switch_ctl0} == SUPPLY_CTL_RST);
   endproperty
   a_clear_sw: assert property (p_clear_sw) else $error("switch controls not cleared");

   property p_release_edge;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !any_rst && $past(any_rst)) |=> (func_en && supply_oe && prog_oe);
   endproperty
   a_release_edge: assert property (p_release_edge) else $error("split release");

   property p_oe_on;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !any_rst) |=> (supply_oe && prog_oe && func_en);
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("outputs not driven");

   property p_freeze;
      @(posedge core_clk) disable iff (sys_rst)
      !clk_en |=> ($stable(ctl_reg) && $stable(func_en) && $stable(supply_oe)
         && $stable(card_supply_switch_ctl0) && $stable(card_prog_switch_ctl1));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   c_global_reset_in: cover property (@(posedge core_clk) !global_reset_in_n_s && !susp_s);
   c_host_bus_reset_in_susp: cover property (@(posedge core_clk) !host_bus_reset_in_n_s && susp_s);
   c_write: cover property (@(posedge core_clk) ctl_we && !any_rst);
   c_release: cover property (@(posedge core_clk) $fell(any_rst));
   c_freeze: cover property (@(posedge core_clk) !clk_en && ctl_we);
endmodule : reset_suspend_control

// ### dv/rst_partner.sv
// partner: system reset logic driving the reset pins and suspend
// assumes requests change just after a core_clk rising edge
`timescale 1ns/1ps
module rst_partner
(
   input wire logic core_clk,
   input wire logic glob_req,
   input wire logic bus_req,
   input wire logic susp_req,
   output logic global_reset_in_n,
   output logic host_bus_reset_in_n,
   output logic suspend_in
);
   initial
   begin
      global_reset_in_n = 1'b0;
      host_bus_reset_in_n = 1'b1;
      suspend_in = 1'b0;
      forever
      begin
         @(posedge core_clk);
         global_reset_in_n <= !glob_req;
         host_bus_reset_in_n <= !bus_req;
         suspend_in <= susp_req;
      end
   end
endmodule : rst_partner

// ### dv/tb_top.sv
// testbench: pin resets, suspend and switch control outputs
// assumes rst_partner drives the pins; clk_en held high except while t_freeze drives it low
`timescale 1ns/1ps
module tb_top;
   import rst_susp_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, glob = 1'b1, bus = 1'b0, susp = 1'b0, we = 1'b0;
   logic ce = 1'b1;
   logic [1:0] sreq = 2'h0, preq = 2'h0;
   logic [7:0] wd = 8'h00, creg;
   logic gr_n, br_n, s_in, c0, c1, p0, p1, soe, poe, fen;
   int num_errors = 0, n_checks = 0;
   always #50 core_clk = !core_clk;
   rst_partner ptn (.core_clk(core_clk), .glob_req(glob), .bus_req(bus), .susp_req(susp),
      .global_reset_in_n(gr_n), .host_bus_reset_in_n(br_n), .suspend_in(s_in));
   reset_suspend_control dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(ce),
      .global_reset_in_n(gr_n), .host_bus_reset_in_n(br_n), .suspend_in(s_in),
      .supply_req(sreq), .prog_req(preq), .ctl_wdata(wd), .ctl_we(we),
      .card_supply_switch_ctl0(c0), .card_supply_switch_ctl1(c1),
      .card_prog_switch_ctl0(p0), .card_prog_switch_ctl1(p1),
      .supply_oe(soe), .prog_oe(poe), .ctl_reg(creg), .func_en(fen));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic wait_fen(input logic lvl);
      for (int i = 0; i < 20 && fen !== lvl; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      if (fen !== lvl)
      begin
         num_errors++;
         give_verdict();
      end
   endtask : wait_fen
   task automatic t_write(input logic [7:0] v);
      @(posedge core_clk);
      wd <= v;
      we <= 1'b1;
      sreq <= v[1:0];
      preq <= v[3:2];
      @(posedge core_clk);
      we <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(creg, v);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, v[3:0]});
      chk({6'h00, soe, poe}, 8'h03);
      $display("write test done");
   endtask : t_write
   task automatic t_freeze(input logic [7:0] v, input logic [7:0] old);
      @(posedge core_clk);
      ce <= 1'b0;
      wd <= v;
      we <= 1'b1;
      sreq <= v[1:0];
      preq <= v[3:2];
      repeat (2) @(posedge core_clk);
      #1;
      chk(creg, old);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, old[3:0]});
      @(posedge core_clk);
      we <= 1'b0;
      ce <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk(creg, old);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, v[3:0]});
      $display("freeze test done");
   endtask : t_freeze
   task automatic t_rst(input logic g, input logic s, input logic [7:0] v);
      logic [3:0] keep;
      keep = s ? v[3:0] : {PROG_CTL_RST, SUPPLY_CTL_RST};
      t_write(v);
      @(posedge core_clk);
      susp <= s;
      repeat (4) @(posedge core_clk);
      glob <= g;
      bus <= !g;
      wait_fen(1'b0);
      chk({6'h00, soe, poe}, 8'h00);
      chk(creg, s ? v : CTL_RST);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, keep});
      @(posedge core_clk);
      wd <= ~v;
      we <= 1'b1;
      sreq <= ~v[1:0];
      preq <= ~v[3:2];
      @(posedge core_clk);
      we <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(creg, s ? v : CTL_RST);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, keep});
      @(posedge core_clk);
      glob <= 1'b0;
      bus <= 1'b0;
      wait_fen(1'b1);
      chk(creg, s ? v : CTL_RST);
      chk({6'h00, soe, poe}, 8'h03);
      chk({4'h0, p1, p0, c1, c0}, {4'h0, ~v[3:0]});
      @(posedge core_clk);
      susp <= 1'b0;
      repeat (4) @(posedge core_clk);
      $display("reset test done");
   endtask : t_rst
   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      glob <= 1'b0;
      wait_fen(1'b1);
      t_write(8'h5A);
      t_freeze(8'h21, 8'h5A);
      t_rst(1'b1, 1'b0, 8'hA5);
      t_rst(1'b1, 1'b1, 8'h3C);
      t_rst(1'b0, 1'b0, 8'hC3);
      t_rst(1'b0, 1'b1, 8'h96);
      give_verdict();
   end
endmodule : tb_top
